//--- src/spa_pkg.sv
package spa_pkg;

    // array geometry
    localparam int NUM_BLOCKS = 2;
    localparam int MC_PER_BLOCK = 16;
    localparam int HALF_CELLS = 8;
    localparam int BLK_INPUTS = 26;
    localparam int LOGIC_TERMS = 64;
    localparam int SPECIAL_TERMS = 6;
    localparam int TERMS_PER_BLOCK = LOGIC_TERMS + SPECIAL_TERMS;
    localparam int TERMS_PER_CLUSTER = 4;
    localparam int CLUSTERS = LOGIC_TERMS / TERMS_PER_CLUSTER;
    localparam int IO_PINS = NUM_BLOCKS * MC_PER_BLOCK;
    localparam int DED_INPUTS = 2;
    localparam int CLK_PINS = 4;
    localparam int CLK_SEL_W = 2;

    // special product terms, numbered after the logic terms
    localparam int TERM_OE_BASE = 64;
    localparam int OE_TERMS_PER_BANK = 2;
    localparam int TERM_AR = 68;
    localparam int TERM_AP = 69;

    // switch matrix sources: pins, fed-back cells, inputs, clock pins
    localparam int SRC_PIN = 0;
    localparam int SRC_FB = 32;
    localparam int SRC_DED = 64;
    localparam int SRC_CLK = 66;
    localparam int MUX_SOURCES = 70;
    localparam int SEL_W = 7;

    // product term mask: true literals low, complemented literals high
    localparam int MASK_W = 2 * BLK_INPUTS;
    localparam int MASK_LO_W = 32;
    localparam int MASK_HI_W = MASK_W - MASK_LO_W;
    localparam logic [MASK_W-1:0] MASK_RESET = {MASK_W{1'b1}};

    // macrocell configuration word
    localparam int MC_USE_LO = 0;
    localparam int MC_USE_OWN = 1;
    localparam int MC_USE_HI = 2;
    localparam int MC_REG = 3;
    localparam int MC_INV = 4;
    localparam int MC_TTYPE = 5;
    localparam int MC_CLK_LSB = 6;
    localparam int MC_OE_LSB = 8;
    localparam int MC_CFG_W = 10;
    localparam logic [MC_CFG_W-1:0] MC_CFG_RESET = 10'h000;
    localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;

    // output enable modes
    localparam logic [1:0] OE_OFF = 2'h0;
    localparam logic [1:0] OE_ON = 2'h1;
    localparam logic [1:0] OE_TERM_A = 2'h2;
    localparam logic [1:0] OE_TERM_B = 2'h3;

    // configuration port
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int OFS_W = 8;
    localparam int ADDR_BLK_BIT = 8;
    localparam logic [OFS_W-1:0] OFS_TERM_BASE = 8'h00;
    localparam logic [OFS_W-1:0] OFS_TERM_END = 8'h8c;
    localparam logic [OFS_W-1:0] OFS_MC_BASE = 8'h90;
    localparam logic [OFS_W-1:0] OFS_MC_END = 8'ha0;
    localparam logic [OFS_W-1:0] OFS_SEL_BASE = 8'ha0;
    localparam logic [OFS_W-1:0] OFS_SEL_END = 8'hba;
    localparam logic [OFS_W-1:0] OFS_STAT_TERMS = 8'hf4;
    localparam logic [ADDR_W-1:0] ADDR_STAT_VALUE = 9'h1f0;
    localparam logic [ADDR_W-1:0] ADDR_STAT_PINS = 9'h1f1;
    localparam logic [ADDR_W-1:0] ADDR_STAT_OE = 9'h1f2;
    localparam logic [ADDR_W-1:0] ADDR_STAT_INPUTS = 9'h1f3;

endpackage

//--- src/spa_pterm.sv
`timescale 1ns/1ns
module spa_pterm (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [spa_pkg::DATA_W-1:0] wdata_i,
    input wire logic [spa_pkg::BLK_INPUTS-1:0] lit_i,
    output logic term_o,
    output logic [spa_pkg::MASK_W-1:0] mask_o
);
    import spa_pkg::*;

    logic [MASK_W-1:0] mask_reg;
    logic [BLK_INPUTS-1:0] true_use;
    logic [BLK_INPUTS-1:0] comp_use;

    // mask starts all ones so an unwritten term is always false
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            mask_reg <= MASK_RESET;
        end else if (wr_lo_i) begin
            mask_reg[MASK_LO_W-1:0] <= wdata_i;
        end else if (wr_hi_i) begin
            mask_reg[MASK_W-1:MASK_LO_W] <= wdata_i[MASK_HI_W-1:0];
        end
    end

    // and of every selected literal; both polarities of one input give 0
    assign true_use = mask_reg[BLK_INPUTS-1:0];
    assign comp_use = mask_reg[MASK_W-1:BLK_INPUTS];
    assign term_o = &((~true_use | lit_i) & (~comp_use | ~lit_i));
    assign mask_o = mask_reg;

endmodule

//--- src/spa_macrocell.sv
`timescale 1ns/1ns
module spa_macrocell (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic sum_i,
    input wire logic edge_i,
    input wire logic ar_i,
    input wire logic ap_i,
    input wire logic reg_mode_i,
    input wire logic invert_i,
    input wire logic ttype_i,
    output logic value_o
);
    import spa_pkg::*;

    logic q_reg;
    logic q_next;

    // d loads the sum, t toggles on a high sum
    always_comb begin
        q_next = ttype_i ? (q_reg ^ sum_i) : sum_i;
    end

    // reset term beats preset term; both ignore the clock pin edge
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            q_reg <= 1'b0;
        end else if (ar_i) begin
            q_reg <= 1'b0;
        end else if (ap_i) begin
            q_reg <= 1'b1;
        end else if (edge_i) begin
            q_reg <= q_next;
        end
    end

    // polarity applies after the register so feedback sees the pin value
    assign value_o = (reg_mode_i ? q_reg : sum_i) ^ invert_i;

endmodule

//--- src/spa_top.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module spa_top (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [spa_pkg::ADDR_W-1:0] cfg_addr_i,
    input wire logic [spa_pkg::DATA_W-1:0] cfg_wdata_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    output logic [spa_pkg::DATA_W-1:0] cfg_rdata_o,
    input wire logic [spa_pkg::IO_PINS-1:0] io_in_i,
    output logic [spa_pkg::IO_PINS-1:0] io_out_o,
    output logic [spa_pkg::IO_PINS-1:0] io_oe_o,
    input wire logic [spa_pkg::DED_INPUTS-1:0] ded_in_i,
    input wire logic [spa_pkg::CLK_PINS-1:0] clk_pin_i
);
    import spa_pkg::*;

    // address split: top bit picks the block, the rest is the offset
    logic acc_blk;
    logic [OFS_W-1:0] ofs;
    logic [OFS_W-1:0] mc_ofs;
    logic [OFS_W-1:0] sel_ofs;
    logic [3:0] mc_idx;
    logic [4:0] sel_idx;
    logic in_term;
    logic in_mc;
    logic in_sel;

    // matrix sources and fed-back cell values
    logic [MUX_SOURCES-1:0] src_w;
    logic [IO_PINS-1:0] fb_reg;
    logic [CLK_PINS-1:0] clk_pin_q_reg;
    logic [CLK_PINS-1:0] clk_rise_w;

    // configuration held outside the product terms
    logic [SEL_W-1:0] sel_reg [NUM_BLOCKS][BLK_INPUTS];
    logic [MC_CFG_W-1:0] mc_cfg_reg [NUM_BLOCKS][MC_PER_BLOCK];

    // nets driven piecewise from the generate loops
    wire [NUM_BLOCKS-1:0][BLK_INPUTS-1:0] lit_w;
    wire [NUM_BLOCKS-1:0][TERMS_PER_BLOCK-1:0] term_w;
    wire [NUM_BLOCKS-1:0][CLUSTERS-1:0] cluster_w;
    wire [MASK_W-1:0] mask_w [NUM_BLOCKS][TERMS_PER_BLOCK];
    wire [IO_PINS-1:0] value_w;
    wire [IO_PINS-1:0] oe_w;

    // output and read-back registers
    logic [IO_PINS-1:0] io_out_reg;
    logic [IO_PINS-1:0] io_oe_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rd_next;

    assign acc_blk = cfg_addr_i[ADDR_BLK_BIT];
    assign ofs = cfg_addr_i[OFS_W-1:0];
    assign mc_ofs = ofs - OFS_MC_BASE;
    assign sel_ofs = ofs - OFS_SEL_BASE;
    assign mc_idx = mc_ofs[3:0];
    assign sel_idx = sel_ofs[4:0];
    assign in_term = (ofs < OFS_TERM_END);
    assign in_mc = (ofs >= OFS_MC_BASE) && (ofs < OFS_MC_END);
    assign in_sel = (ofs >= OFS_SEL_BASE) && (ofs < OFS_SEL_END);

    // every pin and input reaches both blocks through one source vector
    assign src_w = {clk_pin_i, ded_in_i, fb_reg, io_in_i};

    // clock pins are sampled inputs; a rising edge is a low-high pair;
    // history resets high so a pin already high at release is no edge
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            clk_pin_q_reg <= {CLK_PINS{1'b1}};
        end else begin
            clk_pin_q_reg <= clk_pin_i;
        end
    end

    assign clk_rise_w = clk_pin_i & ~clk_pin_q_reg;

    // cell feedback goes through a register so no combinatorial
    // loop can form through the matrix; costs one cycle per pass
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            fb_reg <= {IO_PINS{1'b0}};
        end else begin
            fb_reg <= value_w;
        end
    end

    // matrix selects, one per block input
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            for (int b = 0; b < NUM_BLOCKS; b++) begin
                for (int i = 0; i < BLK_INPUTS; i++) begin
                    sel_reg[b][i] <= SEL_RESET;
                end
            end
        end else if (cfg_wr_i && in_sel) begin
            sel_reg[acc_blk][sel_idx] <= cfg_wdata_i[SEL_W-1:0];
        end
    end

    // macrocell configuration words
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            for (int b = 0; b < NUM_BLOCKS; b++) begin
                for (int n = 0; n < MC_PER_BLOCK; n++) begin
                    mc_cfg_reg[b][n] <= MC_CFG_RESET;
                end
            end
        end else if (cfg_wr_i && in_mc) begin
            mc_cfg_reg[acc_blk][mc_idx] <= cfg_wdata_i[MC_CFG_W-1:0];
        end
    end

    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk

        // each block input picks any source; codes past the last read 0
        for (genvar i = 0; i < BLK_INPUTS; i++) begin : g_in
            assign lit_w[b][i] = (sel_reg[b][i] < SEL_W'(MUX_SOURCES)) ?
                src_w[sel_reg[b][i]] : 1'b0;
        end

        // 64 logic terms, four enable terms, reset term, preset term
        for (genvar t = 0; t < TERMS_PER_BLOCK; t++) begin : g_term
            spa_pterm u_term (
                .ref_clk_i(ref_clk_i),
                .reset_n_i(reset_n_i),
                .wr_lo_i(cfg_wr_i && (acc_blk == 1'(b)) &&
                    (ofs == OFS_W'(OFS_TERM_BASE + 2 * t))),
                .wr_hi_i(cfg_wr_i && (acc_blk == 1'(b)) &&
                    (ofs == OFS_W'(OFS_TERM_BASE + 2 * t + 1))),
                .wdata_i(cfg_wdata_i),
                .lit_i(lit_w[b]),
                .term_o(term_w[b][t]),
                .mask_o(mask_w[b][t])
            );
        end

        // clusters of four logic terms
        for (genvar c = 0; c < CLUSTERS; c++) begin : g_cl
            assign cluster_w[b][c] =
                |term_w[b][TERMS_PER_CLUSTER * c +: TERMS_PER_CLUSTER];
        end

        for (genvar n = 0; n < MC_PER_BLOCK; n++) begin : g_mc
            localparam int G = b * MC_PER_BLOCK + n;
            localparam int HALF_POS = n % HALF_CELLS;
            localparam bit LO_OK = (HALF_POS != 0);
            localparam bit HI_OK = (HALF_POS != HALF_CELLS - 1);
            localparam int LO_IDX = LO_OK ? n - 1 : n;
            localparam int HI_IDX = HI_OK ? n + 1 : n;
            localparam int BANK = n / HALF_CELLS;
            localparam int OE_A = TERM_OE_BASE + OE_TERMS_PER_BANK * BANK;
            localparam int OE_B = OE_A + 1;

            logic [MC_CFG_W-1:0] cfg;
            logic sum;
            logic oe_cell;

            assign cfg = mc_cfg_reg[b][n];

            // own cluster plus neighbours; end cells stay inside their half
            assign sum = (cfg[MC_USE_OWN] & cluster_w[b][n]) |
                (LO_OK & cfg[MC_USE_LO] & cluster_w[b][LO_IDX]) |
                (HI_OK & cfg[MC_USE_HI] & cluster_w[b][HI_IDX]);

            // enable pair depends on which half of the block the cell sits
            always_comb begin
                case (cfg[MC_OE_LSB +: 2])
                    OE_OFF: oe_cell = 1'b0;
                    OE_ON: oe_cell = 1'b1;
                    OE_TERM_A: oe_cell = term_w[b][OE_A];
                    OE_TERM_B: oe_cell = term_w[b][OE_B];
                    default: oe_cell = 1'b0;
                endcase
            end

            assign oe_w[G] = oe_cell;

            // one macrocell per pin cell
            spa_macrocell u_mc (
                .ref_clk_i(ref_clk_i),
                .reset_n_i(reset_n_i),
                .sum_i(sum),
                .edge_i(clk_rise_w[cfg[MC_CLK_LSB +: CLK_SEL_W]]),
                .ar_i(term_w[b][TERM_AR]),
                .ap_i(term_w[b][TERM_AP]),
                .reg_mode_i(cfg[MC_REG]),
                .invert_i(cfg[MC_INV]),
                .ttype_i(cfg[MC_TTYPE]),
                .value_o(value_w[G])
            );
        end
    end

    // pin drivers are registered; the pin input path stays live even
    // while a cell drives it, so a buried cell frees its pin
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            io_out_reg <= {IO_PINS{1'b0}};
            io_oe_reg <= {IO_PINS{1'b0}};
        end else begin
            io_out_reg <= value_w;
            io_oe_reg <= oe_w;
        end
    end

    // read mux; unmapped offsets answer zero
    always_comb begin
        logic [MASK_W-1:0] mask_sel;
        mask_sel = mask_w[acc_blk][ofs[OFS_W-1:1]];
        rd_next = {DATA_W{1'b0}};
        if (cfg_addr_i == ADDR_STAT_VALUE) begin
            rd_next = value_w;
        end else if (cfg_addr_i == ADDR_STAT_PINS) begin
            rd_next = io_in_i;
        end else if (cfg_addr_i == ADDR_STAT_OE) begin
            rd_next = io_oe_reg;
        end else if (cfg_addr_i == ADDR_STAT_INPUTS) begin
            rd_next = DATA_W'({clk_pin_i, ded_in_i});
        end else if (in_term) begin
            if (ofs[0]) begin
                rd_next = DATA_W'(mask_sel[MASK_W-1:MASK_LO_W]);
            end else begin
                rd_next = mask_sel[MASK_LO_W-1:0];
            end
        end else if (in_mc) begin
            rd_next = DATA_W'(mc_cfg_reg[acc_blk][mc_idx]);
        end else if (in_sel) begin
            rd_next = DATA_W'(sel_reg[acc_blk][sel_idx]);
        end else if (ofs == OFS_STAT_TERMS) begin
            // live special terms above the cluster sums, handy for bring-up
            rd_next = DATA_W'({term_w[acc_blk][TERMS_PER_BLOCK-1:LOGIC_TERMS],
                cluster_w[acc_blk]});
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= {DATA_W{1'b0}};
        end else if (cfg_rd_i) begin
            rdata_reg <= rd_next;
        end else begin
            rdata_reg <= {DATA_W{1'b0}};
        end
    end

    assign cfg_rdata_o = rdata_reg;
    assign io_out_o = io_out_reg;
    assign io_oe_o = io_oe_reg;

endmodule

//--- sim/spa_top_asserts.sv
`timescale 1ns/1ns
module spa_top_asserts (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [spa_pkg::ADDR_W-1:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [spa_pkg::DATA_W-1:0] cfg_rdata_o,
    input wire logic [spa_pkg::IO_PINS-1:0] io_in_i,
    input wire logic [spa_pkg::IO_PINS-1:0] io_out_o,
    input wire logic [spa_pkg::IO_PINS-1:0] io_oe_o,
    input wire logic [spa_pkg::DED_INPUTS-1:0] ded_in_i,
    input wire logic [spa_pkg::CLK_PINS-1:0] clk_pin_i
);
    import spa_pkg::*;
    logic touched_reg;

    // until the first write the array holds its reset image and stays quiet
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            touched_reg <= 1'b0;
        end else if (cfg_wr_i) begin
            touched_reg <= 1'b1;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // one read strobe at a given address
    sequence rd_at(logic [ADDR_W-1:0] a);
        cfg_rd_i && cfg_addr_i == a;
    endsequence

    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !reset_n_i |=> io_out_o == '0 && io_oe_o == '0 && cfg_rdata_o == '0)
        else $error("outputs not quiet after reset");
    AST_RDATA_ONLY_READ: assert property (
        cfg_rdata_o != '0 |-> $past(cfg_rd_i))
        else $error("read data without a read");
    AST_UNMAPPED_ZERO: assert property (rd_at(9'h0c0) |=>
        cfg_rdata_o == '0) else $error("unmapped read not zero");
    AST_PIN_STATUS: assert property (rd_at(ADDR_STAT_PINS) |=>
        cfg_rdata_o == $past(io_in_i)) else $error("pin status wrong");
    AST_INPUT_STATUS: assert property (rd_at(ADDR_STAT_INPUTS) |=>
        cfg_rdata_o == {26'h0, $past(clk_pin_i), $past(ded_in_i)})
        else $error("input status wrong");
    AST_VALUE_STATUS: assert property (rd_at(ADDR_STAT_VALUE) |=>
        cfg_rdata_o == io_out_o) else $error("value status wrong");
    AST_IDLE_UNTIL_CONFIG: assert property (
        !touched_reg |-> io_oe_o == '0 && io_out_o == '0)
        else $error("outputs active before configuration");
    AST_TERMS_IDLE: assert property (
        !touched_reg && cfg_rd_i && cfg_addr_i[OFS_W-1:0] == OFS_STAT_TERMS
        |=> cfg_rdata_o == '0) else $error("terms active before config");
endmodule

//--- sim/spa_board.sv
`timescale 1ns/1ns
module spa_board (
    input wire logic [spa_pkg::IO_PINS-1:0] drive_i,
    input wire logic [spa_pkg::IO_PINS-1:0] dev_out_i,
    input wire logic [spa_pkg::IO_PINS-1:0] dev_oe_i,
    output logic [spa_pkg::IO_PINS-1:0] pin_o
);
    // board lets go of a pin the array drives, so the wire shows the array
    always_comb pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & drive_i);
endmodule

//--- sim/spa_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module spa_top_tb;
    import spa_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [ADDR_W-1:0] cfg_addr_i = '0;
    logic [DATA_W-1:0] cfg_wdata_i = '0;
    logic cfg_wr_i = 1'b0;
    logic cfg_rd_i = 1'b0;
    logic [DATA_W-1:0] cfg_rdata_o, d;
    logic [IO_PINS-1:0] io_in_i, io_out_o, io_oe_o;
    logic [IO_PINS-1:0] drv = '0;
    logic [DED_INPUTS-1:0] ded_in_i = 2'h1;
    logic [CLK_PINS-1:0] clk_pin_i = 4'h0;
    logic [15:0] exp16;
    int err_count = 0;
    int total_checks = 0;
    int c, m, n, j, k, bits;

    always #5 ref_clk_i = ~ref_clk_i;

    spa_top i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
        .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
        .ded_in_i(ded_in_i), .clk_pin_i(clk_pin_i));
    spa_board i_board (.drive_i(drv), .dev_out_i(io_out_o),
        .dev_oe_i(io_oe_o), .pin_o(io_in_i));

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // strobes start on a fresh edge so back-to-back calls never collide
    task automatic wr(logic [8:0] a, logic [31:0] v);
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_wdata_i <= v;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b0;
    endtask

    task automatic rd(logic [8:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b0;
        #1 v = cfg_rdata_o;
    endtask

    task automatic term(logic b, int t, logic [31:0] lo, logic [31:0] hi);
        wr({b, 8'(2 * t)}, lo);
        wr({b, 8'(2 * t + 1)}, hi);
    endtask

    // board pin change, then settle just past the chosen edge
    task automatic pins(int p, logic v, int w);
        @(posedge ref_clk_i);
        drv[p] <= v;
        repeat (w) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic clkp(int p, logic v);
        @(posedge ref_clk_i);
        clk_pin_i[p] <= v;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask

    // hang guard
    initial begin
        repeat (50000) @(posedge ref_clk_i);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(9'h090, d); `CHK("cell cfg reset", 0, d);
        rd(9'h000, d); `CHK("mask lo reset", 32'hffffffff, d);
        rd(9'h001, d); `CHK("mask hi reset", 32'h000fffff, d);
        rd({1'b0, OFS_STAT_TERMS}, d); `CHK("terms idle", 0, d);
        rd(9'h0c0, d); `CHK("unmapped", 0, d);
        rd(ADDR_STAT_INPUTS, d); `CHK("inputs", 32'h1, d);
        // block 0 input 0 follows pin 31; walk clusters 0, 7 and 8
        wr(9'h0a0, 32'd31);
        for (k = 0; k < 3; k++) begin
            c = (k == 0) ? 0 : k + 6;
            term(1'b0, 4 * c + 3, 32'h1, 32'h0);
            for (m = 0; m < 4; m++) begin
                bits = (m == 3) ? 7 : (1 << m);
                for (n = 0; n < 16; n++) begin
                    wr({1'b0, 8'h90 + 8'(n)}, 32'h100 | bits);
                end
                exp16 = '0;
                for (n = 0; n < 16; n++) begin
                    for (j = 0; j < 3; j++) begin
                        if (bits[j] && n - 1 + j == c && c / 8 == n / 8) begin
                            exp16[n] = 1'b1;
                        end
                    end
                end
                pins(31, 1'b1, 2);
                `CHK("alloc high", exp16, io_out_o[15:0]);
                `CHK("oe on", 16'hffff, io_oe_o[15:0]);
                rd(ADDR_STAT_VALUE, d); `CHK("values", exp16, d[15:0]);
                pins(31, 1'b0, 1);
                `CHK("alloc low", 0, io_out_o[15:0]);
            end
            term(1'b0, 4 * c + 3, 32'hffffffff, 32'h000fffff);
        end
        // polarity on a combinatorial cell
        term(1'b0, 7, 32'h1, 32'h0);
        wr(9'h091, 32'h112);
        pins(31, 1'b1, 2); `CHK("invert high", 0, io_out_o[1]);
        pins(31, 1'b0, 1); `CHK("invert low", 1, io_out_o[1]);
        // d register on clock pin 2
        wr(9'h091, 32'h18a);
        pins(31, 1'b1, 3); `CHK("no edge", 0, io_out_o[1]);
        clkp(1, 1'b1); `CHK("other clock", 0, io_out_o[1]);
        clkp(2, 1'b1); `CHK("d load", 1, io_out_o[1]);
        pins(31, 1'b0, 1);
        clkp(2, 1'b0); `CHK("fall ignored", 1, io_out_o[1]);
        // t register
        wr(9'h091, 32'h1aa);
        pins(31, 1'b1, 1);
        clkp(2, 1'b1); `CHK("t toggle", 0, io_out_o[1]);
        clkp(2, 1'b0);
        clkp(2, 1'b1); `CHK("t toggle back", 1, io_out_o[1]);
        pins(31, 1'b0, 1);
        clkp(2, 1'b0);
        clkp(2, 1'b1); `CHK("t hold", 1, io_out_o[1]);
        // unclocked reset on pin 30, preset on pin 29
        term(1'b0, 68, 32'h2, 32'h0);
        term(1'b0, 69, 32'h4, 32'h0);
        wr(9'h0a1, 32'd30);
        wr(9'h0a2, 32'd29);
        pins(30, 1'b1, 3); `CHK("async reset", 0, io_out_o[1]);
        pins(30, 1'b0, 1);
        pins(29, 1'b1, 3); `CHK("async preset", 1, io_out_o[1]);
        pins(30, 1'b1, 3); `CHK("reset wins", 0, io_out_o[1]);
        pins(29, 1'b0, 1);
        pins(30, 1'b0, 1);
        // enable modes; bank 1 must ignore bank 0 terms
        term(1'b0, 64, 32'h8, 32'h0);
        wr(9'h0a3, 32'd28);
        wr(9'h099, 32'h202);
        for (m = 0; m < 4; m++) begin
            wr(9'h091, 32'(m << 8) | 32'h2);
            pins(28, 1'b1, 2);
            `CHK("oe mode", m == 1 || m == 2, io_oe_o[1]);
        end
        `CHK("bank split", 0, io_oe_o[9]);
        rd(ADDR_STAT_OE, d); `CHK("oe status", 32'h0000fdfd, d);
        // buried cell feeds block 1, its pin still an input
        wr(9'h091, 32'h002);
        wr(9'h1a0, 32'd33);
        term(1'b1, 0, 32'h1, 32'h0);
        wr(9'h190, 32'h102);
        pins(31, 1'b1, 4); `CHK("feedback", 1, io_out_o[16]);
        pins(1, 1'b1, 1);
        pins(31, 1'b0, 4); `CHK("feedback low", 0, io_out_o[16]);
        rd(ADDR_STAT_PINS, d); `CHK("buried pin", 1, d[1]);
        // clock pin and dedicated input as data
        wr(9'h1a0, 32'd69);
        clkp(3, 1'b1); `CHK("clock as data", 1, io_out_o[16]);
        clkp(3, 1'b0); `CHK("clock data low", 0, io_out_o[16]);
        wr(9'h1a0, 32'd64);
        pins(31, 1'b0, 3); `CHK("dedicated", 1, io_out_o[16]);
        rd(ADDR_STAT_INPUTS, d); `CHK("inputs", 32'h19, d);
        complete_run();
    end
endmodule

bind spa_top spa_top_asserts i_chk (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .io_in_i(io_in_i),
    .io_out_o(io_out_o), .io_oe_o(io_oe_o), .ded_in_i(ded_in_i),
    .clk_pin_i(clk_pin_i));
